/* File: bpps_ctrl.sv */
// Purpose: phase configuration and set-point registers for buck pair A and B
// Assumes: apb master on ref_clk; straps and mode pins are asynchronous
// Notes: zero-wait apb slave; straps are caught once, on the third edge after reset
`timescale 1ns/100ps
`include "bpps_defs.svh"
module bpps_ctrl (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // apb slave
    input  wire bpps_pkg::bpps_apb_req_t apb_req,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // one-time-programmable straps and mode pins
    input  wire logic [1:0]             otp_phase_cfg,
    input  wire logic                   otp_range_a,
    input  wire logic                   otp_range_b,
    input  wire logic                   standby_req,
    input  wire logic                   sleep_req,
    // regulator control
    output bpps_pkg::bpps_target_t      target_a,
    output bpps_pkg::bpps_target_t      target_b,
    output logic [11:0]                 target_a_mv,
    output logic [11:0]                 target_b_mv,
    output logic [1:0]                  target_reserved,
    output logic                        nodes_tied,
    output logic                        fb_from_a_only,
    output logic                        phase_tick_a,
    output logic                        phase_tick_b
);
    import bpps_pkg::*;

    localparam int HALF_CYC = `BPPS_SW_HALF_CYC;

    // setpoint index: 3'd0..5 = A normal, standby, sleep, B normal, standby, sleep
    function automatic logic [2:0] bpps_sp_index(input logic [7:0] addr);
        if (addr >= `BPPS_OFF_A_NORMAL && addr <= `BPPS_OFF_B_SLEEP && addr[1:0] == 2'b00)
            return 3'(addr[7:2] - 6'd1);
        return 3'd7;
    endfunction

    function automatic bpps_phase_t bpps_decode_cfg(input logic [1:0] code);
        unique case (code)
            2'b00, 2'b01: return BPPS_SINGLE;
            2'b10:        return BPPS_DUAL;
            2'b11:        return BPPS_INDEP;
        endcase
    endfunction

    // pin synchronisers: stage one feeds stage two only
    logic [5:0]  sync1_r;
    logic [5:0]  sync2_r;
    logic [1:0]  strap_cnt_r;
    logic        loaded_r;
    logic [1:0]  phase_code_r;
    logic        range_a_r;
    logic        range_b_r;
    bpps_mode_t  mode_r;
    bpps_mode_t  mode_nxt;
    logic [5:0]  setpt_r [0:5];
    logic [31:0] prdata_nxt;
    logic        err_nxt;
    logic [4:0]  sw_cnt_r;
    logic        tied_nxt;
    logic        fb_nxt;
    logic        tick_b_nxt;

    bpps_phase_t  cfg;
    bpps_target_t tgt_a_nxt;
    bpps_target_t tgt_b_nxt;
    logic         paired;
    logic         setup;
    logic         wr_en;
    logic [2:0]   wr_idx;
    logic [2:0]   rd_idx;
    logic [2:0]   sel_a;
    logic [2:0]   sel_b;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= {otp_phase_cfg, otp_range_a, otp_range_b, standby_req, sleep_req};
            sync2_r <= sync1_r;
        end
    end

    // straps caught once after the synchroniser has filled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strap_cnt_r  <= 2'd0;
            loaded_r     <= 1'b0;
            phase_code_r <= `BPPS_RST_PHASE_CFG;
            range_a_r    <= `BPPS_RST_RANGE;
            range_b_r    <= `BPPS_RST_RANGE;
        end else if (!loaded_r) begin
            strap_cnt_r <= strap_cnt_r + 2'd1;
            if (strap_cnt_r == `BPPS_STRAP_WAIT) begin
                loaded_r     <= 1'b1;
                phase_code_r <= sync2_r[5:4];
                range_a_r    <= sync2_r[3];
                range_b_r    <= sync2_r[2];
            end
        end
    end

    // sleep outranks standby when both pins are high
    assign mode_nxt = sync2_r[0] ? BPPS_SLEEP : (sync2_r[1] ? BPPS_STANDBY : BPPS_NORMAL);

    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            mode_r <= BPPS_NORMAL;
        else
            mode_r <= mode_nxt;
    end

    // apb decode; pready is immediate so each transfer is two cycles
    assign setup  = apb_req.psel && !apb_req.penable;
    assign pready = apb_req.psel && apb_req.penable;
    assign wr_en  = pready && apb_req.pwrite && !pslverr;
    assign wr_idx = bpps_sp_index(apb_req.paddr);
    assign rd_idx = wr_idx;
    assign cfg    = bpps_decode_cfg(phase_code_r);
    assign paired = (cfg != BPPS_INDEP);

    // only the six code bits are stored; bit 6 is never writable
    generate
        for (genvar i = 0; i < 6; i++) begin : g_setpt
            always_ff @(posedge ref_clk) begin
                if (!rst_n)
                    setpt_r[i] <= `BPPS_RST_CODE;
                else if (wr_en && wr_idx == 3'(i))
                    setpt_r[i] <= apb_req.pwdata[5:0];
            end
        end
    endgenerate

    // bit 6 of every field of a regulator reads its single range bit
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        err_nxt    = 1'b0;
        if (rd_idx != 3'd7) begin
            prdata_nxt[`BPPS_RANGE_BIT]  = (rd_idx < 3'd3) ? range_a_r : range_b_r;
            prdata_nxt[5:0]              = setpt_r[rd_idx];
        end else if (apb_req.paddr == `BPPS_OFF_CFG) begin
            prdata_nxt[1:0]              = phase_code_r;
            prdata_nxt[`BPPS_CFG_RANGE_A] = range_a_r;
            prdata_nxt[`BPPS_CFG_RANGE_B] = range_b_r;
            prdata_nxt[5:4]              = mode_r;
        end else if (apb_req.paddr == `BPPS_OFF_STATUS) begin
            prdata_nxt[6:0]              = target_a;
            prdata_nxt[`BPPS_STAT_B_LSB +: 7] = target_b;
        end else begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= apb_req.pwrite ? 32'h0000_0000 : prdata_nxt;
            pslverr <= err_nxt;
        end
    end

    // field picked by mode; follows mode every cycle
    assign sel_a = 3'(mode_r);
    // independent B uses its own fields
    assign sel_b = paired ? sel_a : 3'(3'd3 + 3'(mode_r));
    assign tgt_a_nxt = '{range: range_a_r, code: setpt_r[sel_a]};
    // in paired modes A's control governs B as well
    assign tgt_b_nxt = paired ? tgt_a_nxt : '{range: range_b_r, code: setpt_r[sel_b]};

    assign tied_nxt = (cfg == BPPS_SINGLE);
    assign fb_nxt   = paired;
    // dual phase fires B half a period after A
    assign tick_b_nxt = (cfg == BPPS_DUAL) ? (sw_cnt_r == 5'(HALF_CYC)) : (sw_cnt_r == 5'd0);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            target_a       <= '{range: 1'b0, code: `BPPS_RST_CODE};
            target_b       <= '{range: 1'b0, code: `BPPS_RST_CODE};
            nodes_tied     <= 1'b0;
            fb_from_a_only <= 1'b0;
            sw_cnt_r       <= 5'd0;
            phase_tick_a   <= 1'b0;
            phase_tick_b   <= 1'b0;
        end else begin
            target_a       <= tgt_a_nxt;
            target_b       <= tgt_b_nxt;
            nodes_tied     <= tied_nxt;
            fb_from_a_only <= fb_nxt;
            sw_cnt_r       <= (sw_cnt_r == 5'(`BPPS_SW_PERIOD_CYC - 1)) ? 5'd0 : sw_cnt_r + 5'd1;
            phase_tick_a   <= (sw_cnt_r == 5'd0);
            phase_tick_b   <= tick_b_nxt;
        end
    end

    generate
        for (genvar r = 0; r < 2; r++) begin : g_conv
            bpps_mv_conv u_conv (
                .ref_clk  (ref_clk),
                .rst_n    (rst_n),
                .target   (r == 0 ? target_a : target_b),
                .mv       (),
                .reserved (target_reserved[r])
            );
        end
    endgenerate

    bpps_mv_conv u_mv_a (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .target   (target_a),
        .mv       (target_a_mv),
        .reserved ()
    );

    bpps_mv_conv u_mv_b (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .target   (target_b),
        .mv       (target_b_mv),
        .reserved ()
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_write_a_normal;
        apb_req.psel && !apb_req.penable && apb_req.pwrite
            && apb_req.paddr == `BPPS_OFF_A_NORMAL ##1 pready;
    endsequence

    sequence s_mode_change;
        mode_r != $past(mode_r);
    endsequence

    a_decode_indep: assert property (
        loaded_r && phase_code_r == 2'b11 |=> !nodes_tied && !fb_from_a_only)
        else $error("code 11 not independent");
    a_single_tied: assert property (
        loaded_r && phase_code_r[1] == 1'b0 |=> nodes_tied && fb_from_a_only)
        else $error("single phase not tied to A");
    a_pair_follow: assert property (
        paired && $stable(tgt_a_nxt) |=> target_b == target_a)
        else $error("B does not follow A when paired");
    a_dual_offset: assert property (
        cfg == BPPS_DUAL && $stable(cfg) && phase_tick_a |-> ##HALF_CYC phase_tick_b)
        else $error("B tick not half period after A");
    a_indep_own: assert property (
        cfg == BPPS_INDEP && mode_r == BPPS_NORMAL |=> target_b.code == $past(setpt_r[3]))
        else $error("independent B not from own field");
    a_range_ro: assert property (
        loaded_r and s_write_a_normal |=> $stable(range_a_r))
        else $error("range bit changed by write");
    a_copy_range: assert property (
        setup && !apb_req.pwrite && apb_req.paddr == 8'h08 |=> prdata[6] == $past(range_a_r))
        else $error("standby field bit 6 not range");
    a_mode_switch: assert property (
        s_mode_change ##0 (mode_r == BPPS_SLEEP) |=> target_a.code == $past(setpt_r[2]))
        else $error("sleep target not applied");

endmodule // bpps_ctrl

/* File: bpps_defs.svh */
// Purpose: constants for the buck pair phase and set-point controller
// Assumes: apb byte addresses, 40 MHz ref_clk
// Notes: codes and offsets are used by the controller and its converter
//
// How it works
// - phase code 00 or 01 single phase, 10 dual phase, 11 independent
// - single phase: nodes tied, feedback from A only, A governs output
// - dual phase: regulators switch 180 degrees apart, feedback from A only
// - independent: each regulator follows only its own registers
// - range bit 6 of normal set point reads back, ignores writes
// - range 0: code maps to 0.40 V plus 25 mV steps
// - range 1: code maps to 0.800 V plus 50 mV steps, 3.300 V max
// - three six-bit set points per regulator, chosen by operating mode
// - range bit copied into bit 6 of standby and sleep fields
`ifndef BPPS_DEFS_SVH
`define BPPS_DEFS_SVH

`define BPPS_OFF_CFG        8'h00
`define BPPS_OFF_A_NORMAL   8'h04
`define BPPS_OFF_B_SLEEP    8'h18
`define BPPS_OFF_STATUS     8'h1c

`define BPPS_RST_CODE       6'h00
`define BPPS_RST_PHASE_CFG  2'h0
`define BPPS_RST_RANGE      1'h0

`define BPPS_RANGE_BIT      6
`define BPPS_CFG_RANGE_A    2
`define BPPS_CFG_RANGE_B    3
`define BPPS_STAT_B_LSB     8

`define BPPS_LOW_BASE_MV    12'd400
`define BPPS_LOW_STEP_MV    12'd25
`define BPPS_HIGH_BASE_MV   12'd800
`define BPPS_HIGH_STEP_MV   12'd50
`define BPPS_HIGH_MAX_MV    12'd3300

`define BPPS_CLK_MHZ        40
`define BPPS_SW_PERIOD_NS   500
`define BPPS_SW_PERIOD_CYC  ((`BPPS_SW_PERIOD_NS * `BPPS_CLK_MHZ) / 1000)
`define BPPS_SW_HALF_CYC    (`BPPS_SW_PERIOD_CYC / 2)
`define BPPS_STRAP_WAIT     2'd2

`endif

/* File: bpps_pkg.sv */
// Purpose: types for the buck pair phase and set-point controller
// Assumes: nothing beyond the defs header
// Notes: enum codes are written out
package bpps_pkg;

    typedef enum logic [1:0] {
        BPPS_SINGLE = 2'b00,
        BPPS_DUAL   = 2'b01,
        BPPS_INDEP  = 2'b10
    } bpps_phase_t;

    typedef enum logic [1:0] {
        BPPS_NORMAL  = 2'b00,
        BPPS_STANDBY = 2'b01,
        BPPS_SLEEP   = 2'b10
    } bpps_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } bpps_apb_req_t;

    typedef struct packed {
        logic       range;
        logic [5:0] code;
    } bpps_target_t;

endpackage

/* File: bpps_mv_conv.sv */
// Purpose: turn an active set point into its output voltage in millivolts
// Assumes: target comes from flip-flops on ref_clk
// Notes: reserved high-range codes clamp to the top voltage and flag it
`timescale 1ns/100ps
`include "bpps_defs.svh"
module bpps_mv_conv (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // set point in, voltage out
    input  wire bpps_pkg::bpps_target_t target,
    output logic [11:0]                mv,
    output logic                       reserved
);
    import bpps_pkg::*;

    logic [11:0] low_mv;
    logic [11:0] high_mv;
    logic [11:0] mv_nxt;
    logic        rsv_nxt;

    assign low_mv  = 12'(`BPPS_LOW_BASE_MV + `BPPS_LOW_STEP_MV * 12'(target.code));
    assign high_mv = 12'(`BPPS_HIGH_BASE_MV + `BPPS_HIGH_STEP_MV * 12'(target.code));
    assign rsv_nxt = target.range && (high_mv > `BPPS_HIGH_MAX_MV);
    assign mv_nxt  = !target.range ? low_mv : (rsv_nxt ? `BPPS_HIGH_MAX_MV : high_mv);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mv       <= `BPPS_LOW_BASE_MV;
            reserved <= 1'b0;
        end else begin
            mv       <= mv_nxt;
            reserved <= rsv_nxt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_low_range_mv: assert property (
        !target.range |=> mv == 12'(400 + 25 * $past(target.code)))
        else $error("low range voltage wrong");
    a_high_range_mv: assert property (
        target.range |=> (mv <= 12'd3300) && (mv >= 12'd800))
        else $error("high range voltage out of bounds");

endmodule // bpps_mv_conv

/* File: bpps_host_model.sv */
// Purpose: host model that issues apb transfers to the set-point controller
// Assumes: zero-wait slave, pready sampled at rising edges
// Notes: called from the bench; transfers release the bus for one cycle
`timescale 1ns/100ps
module bpps_host_model (
    // clock
    input  wire logic                    ref_clk,
    // apb request and answer
    output bpps_pkg::bpps_apb_req_t      apb_req,
    input  wire logic [31:0]             prdata,
    input  wire logic                    pready,
    input  wire logic                    pslverr
);
    import bpps_pkg::*;

    initial apb_req = '0;

    // callers keep a/b equal when paired, no code at or below 0.6 V
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err, output logic ok);
        apb_req <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        // no cycle count assumed; only the bench watchdog ends a hung transfer
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        ok = (pready === 1'b1);
        apb_req <= '0;
        // idle cycle so the next setup never lands in this time step
        @(posedge ref_clk);
    endtask
endmodule // bpps_host_model

/* File: bpps_ctrl_tb.sv */
// Purpose: self-checking bench for the buck pair phase and set-point controller
// Assumes: 40 MHz ref_clk, synchronous active-low reset, zero-wait apb
// Notes: every phase strap code is run after its own reset
`timescale 1ns/100ps
module bpps_ctrl_tb;
    import bpps_pkg::*;
    logic ref_clk, rst_n, otp_range_a, otp_range_b, standby_req, sleep_req;
    logic [1:0] otp_phase_cfg, target_reserved;
    logic [31:0] prdata;
    logic pready, pslverr, nodes_tied, fb_from_a_only, phase_tick_a, phase_tick_b;
    logic [11:0] target_a_mv, target_b_mv;
    bpps_apb_req_t apb_req;
    bpps_target_t target_a, target_b;
    int err_count = 0;
    int total_checks = 0;
    logic ra, rb, pair;

    bpps_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .otp_phase_cfg(otp_phase_cfg),
        .otp_range_a(otp_range_a), .otp_range_b(otp_range_b), .standby_req(standby_req),
        .sleep_req(sleep_req), .target_a(target_a), .target_b(target_b),
        .target_a_mv(target_a_mv), .target_b_mv(target_b_mv),
        .target_reserved(target_reserved), .nodes_tied(nodes_tied),
        .fb_from_a_only(fb_from_a_only), .phase_tick_a(phase_tick_a),
        .phase_tick_b(phase_tick_b));

    bpps_host_model host (.ref_clk(ref_clk), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    always #12.5 ref_clk = ~ref_clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    function automatic logic [11:0] mv(input logic r, input logic [5:0] c);
        int v;
        v = r ? 800 + 50 * c : 400 + 25 * c;
        return (v > 3300) ? 12'd3300 : 12'(v);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e, ok;
        host.xfer(1'b1, a, d, rd, e, ok);
        chk1(ok, 1'b1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic e, ok;
        host.xfer(1'b0, a, 32'h0, rd, e, ok);
        chk1(ok, 1'b1);
        chk32(rd, exp);
        chk1(e, eerr);
    endtask

    // target settles 4 edges after the pins, one more for the voltage
    task automatic mode_chk(input logic sb, input logic sl, input logic [5:0] ca,
                            input logic [5:0] cb);
        logic rbe;
        rbe = pair ? ra : rb;
        standby_req <= sb;
        sleep_req <= sl;
        repeat (7) @(posedge ref_clk);
        chk32(32'(target_a), 32'({ra, ca}));
        chk32(32'(target_a_mv), 32'(mv(ra, ca)));
        chk32(32'(target_b), 32'({rbe, cb}));
        chk32(32'(target_b_mv), 32'(mv(rbe, cb)));
    endtask

    task automatic tick_chk(input logic dual);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (phase_tick_a !== 1'b1 && n < 40);
        chk1(phase_tick_a, 1'b1);
        chk1(phase_tick_b, !dual);
        repeat (10) @(posedge ref_clk);
        chk1(phase_tick_b, dual);
    endtask

    task automatic run_cfg(input logic [1:0] pc);
        logic [5:0] bn;
        ra = pc[1];
        rb = (pc == 2'b11) ? 1'b0 : ra;
        pair = (pc != 2'b11);
        // codes stay above 0.6 V, and at or above 2.00 V in the high range
        bn = pair ? 6'h1a : 6'h28;
        otp_phase_cfg <= pc;
        otp_range_a <= ra;
        otp_range_b <= rb;
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd_chk(8'h00, {28'h0, rb, ra, pc}, 1'b0);
        chk1(nodes_tied, !pc[1]);
        chk1(fb_from_a_only, pair);
        wr(8'h04, 32'h5a);
        wr(8'h08, 32'h20);
        wr(8'h0c, 32'h24);
        wr(8'h10, {26'h0, bn});
        wr(8'h14, 32'h20);
        wr(8'h18, 32'h24);
        rd_chk(8'h04, {25'h0, ra, 6'h1a}, 1'b0);
        rd_chk(8'h08, {25'h0, ra, 6'h20}, 1'b0);
        rd_chk(8'h18, {25'h0, pair ? ra : rb, 6'h24}, 1'b0);
        rd_chk(8'h20, 32'h0, 1'b1);
        mode_chk(1'b0, 1'b0, 6'h1a, bn);
        rd_chk(8'h1c, {17'h0, pair ? ra : rb, bn, 1'b0, ra, 6'h1a}, 1'b0);
        mode_chk(1'b1, 1'b0, 6'h20, 6'h20);
        rd_chk(8'h00, {26'h0, 2'b01, rb, ra, pc}, 1'b0);
        mode_chk(1'b1, 1'b1, 6'h24, 6'h24);
        rd_chk(8'h00, {26'h0, 2'b10, rb, ra, pc}, 1'b0);
        mode_chk(1'b0, 1'b0, 6'h1a, bn);
        tick_chk(pc == 2'b10);
        if (ra) begin
            wr(8'h04, 32'h3f);
            if (pair)
                wr(8'h10, 32'h3f);
            repeat (4) @(posedge ref_clk);
            chk32(32'(target_reserved), {30'h0, pair, 1'b1});
            chk32(32'(target_a_mv), 32'd3300);
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        otp_phase_cfg = 2'b00;
        otp_range_a = 1'b0;
        otp_range_b = 1'b0;
        standby_req = 1'b0;
        sleep_req = 1'b0;
        for (int c = 0; c < 4; c++)
            run_cfg(2'(c));
        finish_test();
    end

    // the tests take well under 2000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        $display("mismatch %0t watchdog expired", $time);
        finish_test();
    end
endmodule // bpps_ctrl_tb
